// ---- cbt_pkg.sv ----
// Purpose: Constants and types for the camera board init and timing block
// Assumes: One clock, synchronous active-low reset
// Notes:   All counts in clock cycles derive from times and the clock period
package cbt_pkg;
  // Clock and pixel timing
  localparam int CLK_NS     = 50;
  localparam int PIX_NS     = 50;
  localparam int PIX_CYC    = (PIX_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_CLK_NS = 1000000;
  localparam int INT_HALF   = INT_CLK_NS / 2 / CLK_NS;

  // Pixel counts of the readout sequence
  localparam logic [15:0] N_V_DELAY  = 16'h0001;
  localparam logic [15:0] N_V_XFER   = 16'h0028;
  localparam logic [15:0] N_H_DELAY  = 16'h001e;
  localparam logic [15:0] N_PIXELS   = 16'h0460;
  localparam logic [15:0] N_REAL_PIX = 16'h0424;
  localparam logic [15:0] N_LINES    = 16'h0420;
  localparam logic [15:0] N_PD_HOLD  = 16'h0168;
  localparam logic [15:0] N_PD_DELAY = 16'h0320;
  localparam logic [15:0] N_SH_SETUP = 16'h001e;
  localparam logic [15:0] N_SH_PULSE = 16'h0096;
  localparam logic [15:0] N_SH_HOLD  = 16'h0014;
  localparam logic [15:0] N_DUAL_PIX = 16'h0230;

  // Shutter line choices; 1100 lies past the frame, so no pulse
  localparam logic [15:0] SHL_OFF   = 16'h044c;
  localparam logic [15:0] SHL_EIGHT = 16'h039c;
  localparam logic [15:0] SHL_QUART = 16'h0318;
  localparam logic [15:0] SHB_EIGHT = 16'h01ce;
  localparam logic [15:0] SHB_QUART = 16'h018c;

  // Clamp default pixel window
  localparam logic [15:0] CLAMP_START = 16'h0004;
  localparam logic [15:0] CLAMP_END   = 16'h000e;

  // Serial device selects and load table
  localparam logic [2:0] DS_AFE1 = 3'h1;
  localparam logic [2:0] DS_AFE2 = 3'h2;
  localparam logic [2:0] DS_TG   = 3'h3;
  localparam logic [3:0] N_ENTRY = 4'hd;
  localparam logic [5:0] HDR_BITS = 6'h08;
  localparam logic [7:0] AFE_CLAMP = 8'h60;
  localparam logic [7:0] AFE_GAIN  = 8'h14;
  localparam logic [5:0] AFE_BITS  = 6'h08;
  localparam logic [5:0] TG_BITS   = 6'h20;

  // Register map, byte addresses
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h4;
  localparam logic [3:0] A_CLAMP  = 4'h8;
  localparam logic [3:0] A_LINE   = 4'hc;

  typedef struct packed {
    logic [2:0]  dev;
    logic [3:0]  addr;
    logic [5:0]  nbits;
    logic [31:0] data;
  } cbt_entry_t;

  typedef struct packed {
    logic sclock;
    logic sdata;
    logic load_afe1_n;
    logic load_afe2_n;
    logic load_tg_n;
  } cbt_serial_t;

  typedef struct packed {
    logic horiz_clock_phase_one;
    logic horiz_clock_phase_two;
    logic sensor_reset_clock;
    logic vert_clock_phase_two;
    logic vert_two_third_level;
    logic shutter;
    logic optical_black_clamp;
    logic data_sync_clock;
  } cbt_ccd_t;
endpackage : cbt_pkg

// ---- cbt_board_init.sv ----
// Purpose: Board init loader and sensor timing engine for a camera board
// Assumes: Wishbone classic slave, one clock, inputs synchronous
// Notes:   Sequencer counts scale with PIX_CYC; the horizontal, reset and sync clocks toggle every clock in the active line
// What this block does
// - Horizontal clocks and sensor reset clock toggle once per pixel count.
// - Wait one pixel count after horizontal clocks stop before vertical transfer.
// - Second vertical phase high for 40 pixel counts per transfer.
// - Wait 30 pixel counts after vertical transfer before horizontal clocks.
// - Each line has 1120 pixel counts: 1060 real plus 60 overclock.
// - Each frame has 1056 lines including overclock lines.
// - Photodiode transfer holds third level 360 counts, then waits 800.
// - With clocks stopped, wait 30 counts, then shutter pulse for 150.
// - After the shutter pulse, hold off 20 counts before clocks resume.
// - Data sync clock runs at the pixel rate.
// - Short exposure clears the photodiodes at a chosen readout line.
// - Integration select inputs choose full frame down to one eighth.
// - Integration select is taken only at a board reset.
// - Power-up, reset button or remote reset toggle resets all logic.
// - Load front-end defaults first, then timing generator tables and registers.
// - After loading, release timing generator; keep watching its activity and serial.
// - Clamp during dark pixels; defaults fixed, host may move them.
// - Front-end defaults: addresses 0,1 get 0; address 2 gets 96; 3 gets 20.
// - Frame table pointer 0 for single or dual, 1 for binning.
// - Binning switch overrides dual channel switch.
// - Remote reset high forces timing generator reset; falling edge resets board.
// - Pixel count spans a fixed number of system clock cycles.
// - Generate a 1 ms integration clock on an output pin.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module cbt_board_init import cbt_pkg::*; #(
  parameter int P_INT_HALF = INT_HALF
) (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_reset_button,
  input  wire logic        i_remote_reset_input,
  input  wire logic [4:0]  i_integration_select_inputs,
  input  wire logic        i_dual_channel_switch,
  input  wire logic        i_binning_switch,
  input  wire logic        i_host_sload,
  input  wire logic        i_host_sclock,
  input  wire logic        i_host_sdata,
  input  wire logic        i_tg_frame_valid,
  input  wire logic        i_tg_line_valid,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output cbt_serial_t      o_serial,
  output cbt_ccd_t         o_ccd,
  output logic             o_timing_gen_force_reset_n,
  output logic             o_integrate_clock,
  output logic             o_frame_valid,
  output logic             o_line_valid
);
  typedef enum logic [1:0] {LD_SEND, LD_GAP, LD_DONE} cbt_ld_t;
  typedef enum logic [3:0] {
    ST_WAIT, ST_PD_HOLD, ST_PD_DELAY, ST_SH_SETUP, ST_SH_PULSE, ST_SH_HOLD,
    ST_V_DELAY, ST_V_XFER, ST_H_DELAY, ST_H_ACTIVE
  } cbt_st_t;

  logic        button_q, remote_q, board_rst, rst;
  logic [4:0]  int_sel;
  logic        ftp, dual;
  cbt_ld_t     ld_state;
  logic [3:0]  ld_idx;
  logic [5:0]  ld_bit;
  logic        ld_phase;
  logic [39:0] ld_shift;
  cbt_entry_t  entry;
  logic        loaded;
  cbt_st_t     st;
  logic [15:0] cnt, line, pix;
  logic [15:0] shut_line, clamp_start, clamp_end;
  logic        run_en;
  logic [31:0] int_cnt;
  logic        hs_q, hs_rise;
  logic [1:0]  hs_bits;
  logic [2:0]  hs_ds;
  logic        hs_steer;

  // Reset sources: power-up, button rising edge, remote falling edge
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      button_q  <= 1'b0;
      remote_q  <= 1'b0;
      board_rst <= 1'b0;
    end else begin
      button_q  <= i_reset_button;
      remote_q  <= i_remote_reset_input;
      board_rst <= (i_reset_button & ~button_q) |
                   (remote_q & ~i_remote_reset_input);
    end
  end
  assign rst = ~i_rstn | board_rst;

  // Mode straps caught only while reset is held, so later changes wait
  always_ff @(posedge i_clock) begin
    if (rst) begin
      int_sel <= i_integration_select_inputs;
      ftp     <= i_binning_switch;
      dual    <= i_dual_channel_switch & ~i_binning_switch;
    end
  end

  // Shutter line from integration select; unlisted codes turn it off
  always_comb begin
    case (int_sel)
      5'h01:   shut_line = ftp ? SHB_EIGHT : SHL_EIGHT;
      5'h02:   shut_line = ftp ? SHB_QUART : SHL_QUART;
      default: shut_line = SHL_OFF;
    endcase
  end

  // Default load table: front ends first, timing generator last
  always_comb begin
    entry = '0;
    case (ld_idx)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        entry.dev   = ld_idx[2] ? DS_AFE2 : DS_AFE1;
        entry.addr  = {2'h0, ld_idx[1:0]};
        entry.nbits = AFE_BITS;
        entry.data  = (ld_idx[1:0] == 2'h2) ? {24'h0, AFE_CLAMP} :
                      (ld_idx[1:0] == 2'h3) ? {24'h0, AFE_GAIN} : 32'h0;
      end
      4'h8: begin
        entry = '{DS_TG, 4'h2, TG_BITS, 32'h0};  // Program mode first
      end
      4'h9: begin
        entry = '{DS_TG, 4'h0, TG_BITS, {31'h0, ftp}};
      end
      4'ha: begin
        entry = '{DS_TG, 4'h1, TG_BITS, {16'h0, dual ? N_DUAL_PIX : N_PIXELS}};
      end
      4'hb: begin
        entry = '{DS_TG, 4'h3, TG_BITS,
                  {2'h0, N_SH_HOLD[9:0], N_SH_PULSE[9:0], N_SH_SETUP[9:0]}};
      end
      4'hc: begin
        entry = '{DS_TG, 4'h4, TG_BITS, {16'h0, shut_line}};
      end
      default: begin
        entry = '{DS_TG, 4'h2, TG_BITS, 32'h1};  // Execution mode last
      end
    endcase
  end

  // Serial loader: data set with clock low, sampled on the rising edge
  always_ff @(posedge i_clock) begin
    if (rst) begin
      ld_state <= LD_GAP;
      ld_idx   <= '0;
      ld_bit   <= '0;
      ld_phase <= 1'b0;
      ld_shift <= '0;
      loaded   <= 1'b0;
    end else begin
      case (ld_state)
        LD_GAP: begin
          ld_shift <= {entry.data[31:0], entry.addr, 1'b0,
                       entry.dev[0], entry.dev[1], entry.dev[2]};
          ld_bit   <= '0;
          ld_phase <= 1'b0;
          ld_state <= LD_SEND;
        end
        LD_SEND: begin
          ld_phase <= ~ld_phase;
          if (ld_phase) begin
            ld_shift <= {1'b0, ld_shift[39:1]};
            ld_bit   <= ld_bit + 6'h01;
            if (ld_bit == entry.nbits + HDR_BITS - 6'h01) begin
              if (ld_idx == N_ENTRY) begin
                ld_state <= LD_DONE;
                loaded   <= 1'b1;
              end else begin
                ld_idx   <= ld_idx + 4'h1;
                ld_state <= LD_GAP;
              end
            end
          end
        end
        LD_DONE: ld_state <= LD_DONE;
        default: ld_state <= LD_GAP;
      endcase
    end
  end

  // Host serial steering: first three bits pick the target device
  always_ff @(posedge i_clock) begin
    if (rst) begin
      hs_q     <= 1'b0;
      hs_bits  <= '0;
      hs_ds    <= '0;
      hs_steer <= 1'b0;
    end else begin
      hs_q <= i_host_sclock;
      if (i_host_sload || !loaded) begin
        hs_bits  <= '0;
        hs_steer <= 1'b0;
      end else if (hs_rise && !hs_steer) begin
        hs_ds   <= {hs_ds[1:0], i_host_sdata};
        hs_bits <= hs_bits + 2'h1;
        if (hs_bits == 2'h2) begin
          hs_steer <= 1'b1;
        end
      end
    end
  end
  assign hs_rise = i_host_sclock & ~hs_q;

  // Serial pins: loader owns them until done, then the host may pass
  always_ff @(posedge i_clock) begin
    if (rst) begin
      o_serial <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    end else if (ld_state == LD_SEND) begin
      o_serial.sclock      <= ld_phase;
      o_serial.sdata       <= ld_shift[0];
      o_serial.load_afe1_n <= entry.dev != DS_AFE1;
      o_serial.load_afe2_n <= entry.dev != DS_AFE2;
      o_serial.load_tg_n   <= entry.dev != DS_TG;
    end else if (hs_steer) begin
      o_serial.sclock      <= i_host_sclock;
      o_serial.sdata       <= i_host_sdata;
      o_serial.load_afe1_n <= hs_ds != DS_AFE1;
      o_serial.load_afe2_n <= hs_ds != DS_AFE2;
      o_serial.load_tg_n   <= hs_ds != DS_TG;
    end else begin
      o_serial <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    end
  end

  // Held by remote input, its falling edge, or until loaded; no blip before reset
  always_ff @(posedge i_clock) begin
    if (rst) begin
      o_timing_gen_force_reset_n <= 1'b0;
    end else begin
      o_timing_gen_force_reset_n <= loaded & ~i_remote_reset_input & ~remote_q;
    end
  end

  // Monitor the generator's valids once it is running
  always_ff @(posedge i_clock) begin
    if (rst) begin
      o_frame_valid <= 1'b0;
      o_line_valid  <= 1'b0;
    end else begin
      o_frame_valid <= loaded & i_tg_frame_valid;
      o_line_valid  <= loaded & i_tg_line_valid;
    end
  end

  // 1 ms integration clock, free running after reset
  always_ff @(posedge i_clock) begin
    if (rst) begin
      int_cnt           <= '0;
      o_integrate_clock <= 1'b0;
    end else if (int_cnt == 32'(P_INT_HALF - 1)) begin
      int_cnt           <= '0;
      o_integrate_clock <= ~o_integrate_clock;
    end else begin
      int_cnt <= int_cnt + 32'h1;
    end
  end

  // Clamp window registers; software moves it after power-up
  always_ff @(posedge i_clock) begin
    if (rst) begin
      run_en      <= 1'b1;
      clamp_start <= CLAMP_START;
      clamp_end   <= CLAMP_END;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
      if (wb_adr_i == A_CTRL && wb_sel_i[0]) begin
        run_en <= wb_dat_i[0];
      end
      if (wb_adr_i == A_CLAMP) begin
        if (wb_sel_i[0]) clamp_start[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) clamp_start[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) clamp_end[7:0]    <= wb_dat_i[23:16];
        if (wb_sel_i[3]) clamp_end[15:8]   <= wb_dat_i[31:24];
      end
    end
  end

  // Wishbone answer one cycle after the request; unmapped reads zero
  always_ff @(posedge i_clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        A_CTRL:   wb_dat_o <= {31'h0, run_en};
        A_STATUS: wb_dat_o <= {17'h0, dual, ftp, int_sel,
                               st, 3'h0, loaded};
        A_CLAMP:  wb_dat_o <= {clamp_end, clamp_start};
        A_LINE:   wb_dat_o <= {pix, line};
        default:  wb_dat_o <= '0;
      endcase
    end
  end

  // Readout sequencer; counts are pixel counts scaled by PIX_CYC
  always_ff @(posedge i_clock) begin
    if (rst) begin
      st   <= ST_WAIT;
      cnt  <= '0;
      line <= '0;
      pix  <= '0;
    end else begin
      cnt <= cnt + 16'h1;
      case (st)
        ST_WAIT: begin
          cnt <= '0;
          if (loaded && run_en) st <= ST_PD_HOLD;
        end
        ST_PD_HOLD: if (cnt == 16'(N_PD_HOLD * PIX_CYC - 1)) begin
          cnt <= '0;
          st  <= ST_PD_DELAY;
        end
        ST_PD_DELAY: if (cnt == 16'(N_PD_DELAY * PIX_CYC - 1)) begin
          cnt  <= '0;
          line <= '0;
          st   <= (shut_line == 16'h0) ? ST_SH_SETUP : ST_V_DELAY;
        end
        ST_SH_SETUP: if (cnt == 16'(N_SH_SETUP * PIX_CYC - 1)) begin
          cnt <= '0;
          st  <= ST_SH_PULSE;
        end
        ST_SH_PULSE: if (cnt == 16'(N_SH_PULSE * PIX_CYC - 1)) begin
          cnt <= '0;
          st  <= ST_SH_HOLD;
        end
        ST_SH_HOLD: if (cnt == 16'(N_SH_HOLD * PIX_CYC - 1)) begin
          cnt <= '0;
          st  <= ST_V_DELAY;
        end
        ST_V_DELAY: if (cnt == 16'(N_V_DELAY * PIX_CYC - 1)) begin
          cnt <= '0;
          st  <= ST_V_XFER;
        end
        ST_V_XFER: if (cnt == 16'(N_V_XFER * PIX_CYC - 1)) begin
          cnt <= '0;
          st  <= ST_H_DELAY;
        end
        ST_H_DELAY: if (cnt == 16'(N_H_DELAY * PIX_CYC - 1)) begin
          cnt <= '0;
          pix <= '0;
          st  <= ST_H_ACTIVE;
        end
        ST_H_ACTIVE: begin
          if (cnt == 16'(PIX_CYC - 1)) begin
            cnt <= '0;
            pix <= pix + 16'h1;
            if (pix == N_PIXELS - 16'h1) begin
              line <= line + 16'h1;
              cnt  <= '0;
              if (line == N_LINES - 16'h1) begin
                st <= run_en ? ST_PD_HOLD : ST_WAIT;
              end else if (line + 16'h1 == shut_line) begin
                st <= ST_SH_SETUP;
              end else begin
                st <= ST_V_DELAY;
              end
            end
          end
        end
        default: st <= ST_WAIT;
      endcase
    end
  end

  // Sensor drive pins; horizontal phases only toggle in the active line
  always_ff @(posedge i_clock) begin
    if (rst) begin
      o_ccd <= '0;
    end else begin
      if (st == ST_H_ACTIVE) begin
        o_ccd.horiz_clock_phase_one <= ~o_ccd.horiz_clock_phase_one;
        o_ccd.horiz_clock_phase_two <= o_ccd.horiz_clock_phase_one;
        o_ccd.sensor_reset_clock    <= ~o_ccd.sensor_reset_clock;
        o_ccd.data_sync_clock       <= ~o_ccd.data_sync_clock;
      end else begin
        o_ccd.horiz_clock_phase_one <= 1'b0;
        o_ccd.horiz_clock_phase_two <= 1'b1;
        o_ccd.sensor_reset_clock    <= 1'b0;
        o_ccd.data_sync_clock       <= 1'b0;
      end
      o_ccd.vert_clock_phase_two <= (st == ST_V_XFER) | (st == ST_PD_HOLD);
      o_ccd.vert_two_third_level <= st == ST_PD_HOLD;
      o_ccd.shutter              <= st == ST_SH_PULSE;
      // Clamp sits in the dark lead-in pixels, never in overclock
      o_ccd.optical_black_clamp  <= (st == ST_H_ACTIVE) && (pix >= clamp_start) &&
                                    (pix <= clamp_end) && (pix < N_REAL_PIX);
    end
  end
endmodule : cbt_board_init

// ---- cbt_board_init_properties.sv ----
// Purpose: Port checks for the board init and timing block
// Assumes: One clock per pixel count, synchronous active-low reset
// Notes:   Runs cut short by an internal reset are skipped
`timescale 1ns/1ps
module cbt_board_init_properties import cbt_pkg::*; (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_reset_button,
  input wire logic        i_remote_reset_input,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire cbt_serial_t o_serial,
  input wire cbt_ccd_t    o_ccd,
  input wire logic        o_timing_gen_force_reset_n
);
  logic [11:0] v2_len;
  logic [11:0] th_len;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // High-run lengths; a fall reads the full length one cycle late
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      v2_len <= 12'h000;
      th_len <= 12'h000;
    end else begin
      v2_len <= o_ccd.vert_clock_phase_two ? v2_len + 12'h001 : 12'h000;
      th_len <= o_ccd.vert_two_third_level ? th_len + 12'h001 : 12'h000;
    end
  end
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_hold; i_remote_reset_input || $fell(i_remote_reset_input)
    |=> !o_timing_gen_force_reset_n; endproperty
  a_hold: assert property (p_hold) else $error("remote high did not hold reset");
  property p_reload; $rose(i_reset_button) || $fell(i_remote_reset_input)
    |-> ##[2:6] !o_serial.load_afe1_n; endproperty
  a_reload: assert property (p_reload) else $error("reset did not restart load");
  property p_release; $rose(o_timing_gen_force_reset_n)
    |-> o_serial.load_tg_n && o_serial.load_afe1_n && o_serial.load_afe2_n; endproperty
  a_release: assert property (p_release) else $error("released during load");
  property p_onesel;
    $onehot0(~{o_serial.load_afe1_n, o_serial.load_afe2_n, o_serial.load_tg_n}); endproperty
  a_onesel: assert property (p_onesel) else $error("two load selects low");
  property p_vxfer; $fell(o_ccd.vert_clock_phase_two) && !$past(o_ccd.vert_two_third_level)
    && o_timing_gen_force_reset_n |-> v2_len == 12'h028; endproperty
  a_vxfer: assert property (p_vxfer) else $error("vertical transfer length");
  property p_pdhold; $fell(o_ccd.vert_two_third_level) && o_timing_gen_force_reset_n
    |-> th_len == 12'h168; endproperty
  a_pdhold: assert property (p_pdhold) else $error("third level length");
  property p_sync; $rose(o_ccd.data_sync_clock) |=> $fell(o_ccd.data_sync_clock); endproperty
  a_sync: assert property (p_sync) else $error("sync clock not pixel rate");
endmodule : cbt_board_init_properties
bind cbt_board_init cbt_board_init_properties i_cbt_board_init_properties (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_reset_button(i_reset_button),
  .i_remote_reset_input(i_remote_reset_input), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .o_serial(o_serial), .o_ccd(o_ccd),
  .o_timing_gen_force_reset_n(o_timing_gen_force_reset_n));

// ---- cbt_chip_model.sv ----
// Purpose: Front-end and timing generator chips behind the serial link
// Assumes: Chips take data on the serial clock rise while selected
// Notes:   Logs every frame of more than eight bits; timing generator always reports a frame
`timescale 1ns/1ps
module cbt_chip_model import cbt_pkg::*; (
  input  wire cbt_serial_t i_serial,
  input  wire logic        i_clock,
  output logic             o_frame_valid,
  output logic             o_line_valid
);
  logic [7:0]  hdr [0:63];
  logic [31:0] dat [0:63];
  logic [7:0]  h;
  logic [31:0] d;
  logic        sck_q;
  int          bits;
  int          nfr;
  initial begin
    nfr = 0;
    bits = 0;
    sck_q = 1'b0;
    o_frame_valid = 1'b1;
    o_line_valid = 1'b0;
  end
  // Frame closes when every select is high; data arrives LSB first
  always @(posedge i_clock) begin
    if (&{i_serial.load_afe1_n, i_serial.load_afe2_n, i_serial.load_tg_n}) begin
      if (bits > 8) begin
        hdr[nfr] = h;
        dat[nfr] = d >> (40 - bits);
        nfr++;
      end
      bits = 0;
    end else if (i_serial.sclock && !sck_q) begin
      if (bits < 8) h = {h[6:0], i_serial.sdata};
      else d = {i_serial.sdata, d[31:1]};
      bits++;
    end
    sck_q = i_serial.sclock;
    o_line_valid <= ~o_line_valid;
  end
endmodule : cbt_chip_model

// ---- cbt_board_init_bench.sv ----
// Purpose: Self-checking bench for the board init and timing block
// Assumes: 20 MHz clock, one cycle per pixel count
// Notes:   Byte selects are tied off
`timescale 1ns/1ps
module cbt_board_init_bench import cbt_pkg::*;;
  logic        i_clock, rstn, btn, rmt, dual, bin, cyc, stb, we, ack, frc, fv, tfv, tlv;
  logic        hl, hc, hd, ic, lv;
  logic [4:0]  isel;
  logic [3:0]  adr;
  logic [31:0] wd, rd, q;
  cbt_serial_t ser;
  cbt_ccd_t    ccd;
  int          miscompares, checked, base;
  cbt_board_init #(.P_INT_HALF(8)) i_cbt_board_init (.i_clock(i_clock), .i_rstn(rstn),
    .i_reset_button(btn), .i_remote_reset_input(rmt), .i_integration_select_inputs(isel),
    .i_dual_channel_switch(dual), .i_binning_switch(bin), .i_host_sload(hl),
    .i_host_sclock(hc), .i_host_sdata(hd), .i_tg_frame_valid(tfv), .i_tg_line_valid(tlv),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(q), .wb_ack_o(ack), .o_serial(ser), .o_ccd(ccd),
    .o_timing_gen_force_reset_n(frc), .o_integrate_clock(ic), .o_frame_valid(fv),
    .o_line_valid(lv));
  cbt_chip_model i_cbt_chip_model (.i_serial(ser), .i_clock(i_clock), .o_frame_valid(tfv),
    .o_line_valid(tlv));
  // Clock at 20 MHz
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  // Classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = q;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wait_frames(input int n);
    for (int i = 0; i < 3000 && i_cbt_chip_model.nfr < n; i++) @(posedge i_clock);
  endtask : wait_frames
  task automatic frames(input int b, input logic f);
    logic [3:0] a;
    for (int i = 0; i < 8; i++) begin
      a = 4'(i % 4);
      chk("afe hdr", {24'h0, (i < 4 ? 3'h1 : 3'h2), 1'b0, a[0], a[1], a[2], a[3]},
        {24'h0, i_cbt_chip_model.hdr[b + i]});
      chk("afe data", a == 4'h2 ? 32'h60 : a == 4'h3 ? 32'h14 : 32'h0,
        i_cbt_chip_model.dat[b + i]);
    end
    chk("tg hdr", 32'h60, {24'h0, i_cbt_chip_model.hdr[b + 9]});
    chk("tg ftp", {31'h0, f}, i_cbt_chip_model.dat[b + 9]);
    chk("tg run", 32'h1, i_cbt_chip_model.dat[b + 13]);
  endtask : frames
  // Cycles that a sensor line stays at one level, with clock and clamp high counts
  task automatic run(input int k, input logic v, output int n, output int h, output int s,
                     output int c);
    n = 0;
    h = 0;
    s = 0;
    c = 0;
    while (ccd[k] === v && n < 5000) begin
      n++;
      h += ccd[7];
      s += ccd[0];
      c += ccd[1];
      @(posedge i_clock);
    end
  endtask : run
  task automatic t_load;
    wait_frames(3);
    chk("fv in load", 32'h0, {31'h0, fv});
    wait_frames(14);
    frames(0, 1'b0);
    $display("load test done");
  endtask : t_load
  task automatic t_seq;
    int n, h, s, c;
    for (int i = 0; i < 3000 && ccd[3] !== 1'b1; i++) @(posedge i_clock);
    run(3, 1'b1, n, h, s, c);
    chk("pd hold", 32'd360, n);
    run(4, 1'b0, n, h, s, c);
    chk("pd delay", 32'd801, n);
    run(4, 1'b1, n, h, s, c);
    chk("v xfer", 32'd40, n);
    run(4, 1'b0, n, h, s, c);
    chk("line span", 32'd1151, n);
    chk("h1 highs", 32'd560, h);
    chk("sync highs", 32'd560, s);
    chk("clamp pixels", 32'd11, c);
    run(4, 1'b1, n, h, s, c);
    chk("v xfer 2", 32'd40, n);
    chk("fv run", 32'h1, {31'h0, fv});
    chk("tg free", 32'h1, {31'h0, frc});
    $display("timing test done");
  endtask : t_seq
  task automatic t_regs;
    wb(1'b0, A_CLAMP, 32'h0);
    chk("clamp reset", 32'h000e0004, rd);
    wb(1'b1, A_CLAMP, 32'h00200008);
    wb(1'b0, A_CLAMP, 32'h0);
    chk("clamp moved", 32'h00200008, rd);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("register test done");
  endtask : t_regs
  // Straps only count at a board reset; binning wins over dual
  task automatic t_straps;
    base = i_cbt_chip_model.nfr;
    isel <= 5'h01;
    dual <= 1'b1;
    bin <= 1'b1;
    rmt <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk("tg held", 32'h0, {31'h0, frc});
    rmt <= 1'b0;
    wait_frames(base + 14);
    frames(base, 1'b1);
    wb(1'b0, A_STATUS, 32'h0);
    chk("sel one", 32'h1, {27'h0, rd[12:8]});
    chk("binning", 32'h1, {31'h0, rd[13]});
    chk("dual off", 32'h0, {31'h0, rd[14]});
    isel <= 5'h02;
    dual <= 1'b0;
    bin <= 1'b0;
    wb(1'b0, A_STATUS, 32'h0);
    chk("sel held", 32'h1, {27'h0, rd[12:8]});
    base = i_cbt_chip_model.nfr;
    btn <= 1'b1;
    @(posedge i_clock);
    btn <= 1'b0;
    wait_frames(base + 14);
    frames(base, 1'b0);
    wb(1'b0, A_STATUS, 32'h0);
    chk("sel two", 32'h2, {27'h0, rd[12:8]});
    $display("strap test done");
  endtask : t_straps
  // Host stream of select 011 steers to the timing generator after load
  task automatic t_host;
    int n;
    hl <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clock);
      hc <= i[0];
      hd <= i > 1;
    end
    repeat (3) @(posedge i_clock);
    chk("host tg sel", 32'h0, {31'h0, ser.load_tg_n});
    chk("host afe sel", 32'h3, {30'h0, ser.load_afe1_n, ser.load_afe2_n});
    hl <= 1'b1;
    hc <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk("host end", 32'h1, {31'h0, ser.load_tg_n});
    chk("lv follows", {31'h0, ~tlv}, {31'h0, lv});
    while (ic !== 1'b0) @(posedge i_clock);
    while (ic !== 1'b1) @(posedge i_clock);
    n = 0;
    while (ic === 1'b1 && n < 40) begin
      n++;
      @(posedge i_clock);
    end
    chk("int clock half", 32'd8, n);
    $display("host test done");
  endtask : t_host
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // Main sequence; timing test must follow the load at once
  initial begin
    miscompares = 0;
    checked = 0;
    {rstn, btn, rmt, dual, bin, cyc, stb, we} = 8'h00;
    {hl, hc, hd} = 3'h4;
    isel = 5'h00;
    adr = 4'h0;
    wd = 32'h0;
    repeat (3) @(posedge i_clock);
    rstn <= 1'b1;
    t_load();
    t_seq();
    t_regs();
    t_host();
    t_straps();
    results();
  end
  // Watchdog well past the expected run of about 4700 cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    $display("[ERR] watchdog expected done seen hang");
    results();
  end
endmodule : cbt_board_init_bench
